// ==== core/asc_ctrl.sv ====
// What this block does
// - keep both selects asserted through the whole select-to-end-of-write window.
// - strobe stays high for every read cycle.
// - never drive data while the memory may still be driving.
// - strobe low time with gate low covers float delay plus data window.
// - with gate high the strobe low time still covers float delay plus data window.
// - hold write address stable from start to end of write.
// - present write data for the data window before write ends.
`default_nettype none
module asc_ctrl
  import asc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [asc_pkg::ASC_ADDR_W-1:0] req_addr_i,
  input wire logic [asc_pkg::ASC_DATA_W-1:0] req_wdata_i,
  output logic ready_o,
  output logic rvalid_o,
  output logic [asc_pkg::ASC_DATA_W-1:0] rdata_o,
  output logic [asc_pkg::ASC_ADDR_W-1:0] mem_addr_o,
  output logic select_low_n_o,
  output logic select_high_o,
  output logic write_n_o,
  output logic gate_n_o,
  input wire logic [asc_pkg::ASC_DATA_W-1:0] dq_i,
  output logic [asc_pkg::ASC_DATA_W-1:0] dq_o,
  output logic dq_oe_n_o
);
  ////////////////////////////////////////////////////////////////
  // elaboration checks: each phase length must fit the cycle counter,
  // otherwise the cast below would wrap and shorten a strobe silently
  if (ASC_WR_CYC >= (1 << ASC_CNT_W))
  begin : g_chk_wr
    $error("write phase does not fit the cycle counter");
  end
  if (ASC_RD_CYC >= (1 << ASC_CNT_W))
  begin : g_chk_rd
    $error("read phase does not fit the cycle counter");
  end
  if (ASC_TURN_CYC >= (1 << ASC_CNT_W))
  begin : g_chk_turn
    $error("turnaround does not fit the cycle counter");
  end
  // a zero length would wrap the counter to fifteen and stretch the phase to sixteen cycles
  if (ASC_WR_CYC < 1 || ASC_RD_CYC < 1 || ASC_TURN_CYC < 1)
  begin : g_chk_zero
    $error("phase lengths must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////
  // memory data pins enter through the two-stage synchroniser
  asc_pin_if pins ();
  assign pins.dq_in = dq_i;
  asc_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pins(pins)
  );

  localparam logic [ASC_CNT_W-1:0] WR_LEN = ASC_CNT_W'(ASC_WR_CYC);
  localparam logic [ASC_CNT_W-1:0] RD_LEN = ASC_CNT_W'(ASC_RD_CYC);
  localparam logic [ASC_CNT_W-1:0] TURN_LEN = ASC_CNT_W'(ASC_TURN_CYC);

  asc_state_e state;
  logic [ASC_CNT_W-1:0] cnt;
  logic take;
  assign take = (state == ASC_IDLE) && req_i;

  // last cycle of a strobe phase; the pin logic decodes it
  function automatic logic phase_end(input asc_state_e st, input logic [ASC_CNT_W-1:0] c);
    return ((st == ASC_WRITE) || (st == ASC_READ)) && (c == ASC_CNT_ONE);
  endfunction

  // last cycle of a read phase; the capture stage decodes it
  function automatic logic read_end(input asc_state_e st, input logic [ASC_CNT_W-1:0] c);
    return (st == ASC_READ) && (c == ASC_CNT_ONE);
  endfunction

  // read capture lags the pins by one edge to cover the second sync stage
  logic rd_pend;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ASC_IDLE;
      cnt <= ASC_CNT_ZERO;
    end
    else
    begin
      case (state)
        ASC_IDLE:
        begin
          if (req_i)
          begin
            state <= req_write_i ? ASC_WRITE : ASC_READ;
            // strobe length covers float plus window
            cnt <= req_write_i ? WR_LEN : RD_LEN;
          end
        end
        ASC_WRITE, ASC_READ:
        begin
          if (cnt == ASC_CNT_ONE)
          begin
            state <= ASC_TURN;
            cnt <= TURN_LEN;
          end
          else
            cnt <= cnt - ASC_CNT_ONE;
        end
        ASC_TURN:
        begin
          // wait out release before next cycle
          if (cnt == ASC_CNT_ONE)
            state <= ASC_IDLE;
          else
            cnt <= cnt - ASC_CNT_ONE;
        end
        default: state <= ASC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // pins: on writes selects assert as the strobe falls and the high gate keeps the memory floating
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      select_low_n_o <= 1'b1;
      select_high_o <= 1'b0;
      write_n_o <= 1'b1;
      gate_n_o <= 1'b1;
      dq_oe_n_o <= 1'b1;
      dq_o <= '0;
      mem_addr_o <= '0;
    end
    else if (take)
    begin
      // address held for the whole access
      mem_addr_o <= req_addr_i;
      // selects stay asserted through the access
      select_low_n_o <= 1'b0;
      select_high_o <= 1'b1;
      // strobe high on reads; overlap forms the write
      write_n_o <= !req_write_i;
      gate_n_o <= req_write_i;
      // drive only after turnaround, memory gate high
      dq_oe_n_o <= !req_write_i;
      // data valid the whole strobe time
      dq_o <= req_wdata_i;
    end
    else if (phase_end(state, cnt))
    begin
      select_low_n_o <= 1'b1;
      select_high_o <= 1'b0;
      write_n_o <= 1'b1;
      gate_n_o <= 1'b1;
    end
    // data driven one edge past strobe rise so the memory
    // never latches a half-released bus; its gate is high meanwhile
    else if (state == ASC_TURN)
      dq_oe_n_o <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // byte settles within access time, first stage takes it one edge
  // after the take, second stage one edge later, so capture comes late;
  // sampling at the end of the phase itself would return the old bus
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rd_pend <= 1'b0;
    else
      rd_pend <= read_end(state, cnt);
  end

  // rdata keeps the last byte until the next read completes
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rvalid_o <= 1'b0;
      rdata_o <= '0;
    end
    else
    begin
      rvalid_o <= rd_pend;
      if (rd_pend)
        rdata_o <= pins.dq_sync;
    end
  end

  ////////////////////////////////////////////////////////////////
  // ready drops while a request is pending so a held request is not
  // mistaken for a second one; it returns only once the engine idles
  // and the requester has let go of the request
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ready_o <= 1'b0;
    else
      ready_o <= (state == ASC_IDLE) && !req_i;
  end
endmodule : asc_ctrl
`default_nettype wire

// ==== core/asc_pkg.sv ====
`default_nettype none
package asc_pkg;
  localparam int ASC_ADDR_W = 17;
  localparam int ASC_DATA_W = 8;
  localparam int ASC_CLK_MHZ = 20;
  localparam int ASC_CLK_PS = 1000000 / ASC_CLK_MHZ;
  // slowest grade figures, ns
  localparam int ASC_T_CW_NS = 15;
  localparam int ASC_T_WP_NS = 15;
  localparam int ASC_T_DW_NS = 9;
  localparam int ASC_T_WHZ_NS = 8;
  localparam int ASC_T_AW_NS = 15;
  localparam int ASC_T_AA_NS = 20;
  localparam int ASC_T_OE_NS = 8;
  localparam int ASC_T_CHZ_NS = 8;
  localparam int ASC_T_OHZ_NS = 7;
  localparam int ASC_T_OW_NS = 4;
  localparam int ASC_T_OH_NS = 4;
  // least times round up, never below one cycle
  function automatic int asc_cyc(input int ns);
    int c;
    c = (ns * 1000 + ASC_CLK_PS - 1) / ASC_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int ASC_WR_CYC = asc_cyc(ASC_T_WHZ_NS + ASC_T_DW_NS);
  localparam int ASC_RD_CYC = asc_cyc(ASC_T_AA_NS) + 1;
  localparam int ASC_TURN_CYC = asc_cyc(ASC_T_CHZ_NS);
  localparam int ASC_CNT_W = 4;
  localparam logic [ASC_CNT_W-1:0] ASC_CNT_ZERO = 4'h0;
  localparam logic [ASC_CNT_W-1:0] ASC_CNT_ONE = 4'h1;
  typedef enum logic [2:0] {ASC_IDLE, ASC_WRITE, ASC_READ, ASC_TURN} asc_state_e;
endpackage : asc_pkg
`default_nettype wire

// ==== core/asc_pin_if.sv ====
`default_nettype none
interface asc_pin_if;
  import asc_pkg::*;
  logic [ASC_DATA_W-1:0] dq_in;
  logic [ASC_DATA_W-1:0] dq_sync;
  modport ctl (input dq_sync, output dq_in);
  modport syn (input dq_in, output dq_sync);
endinterface : asc_pin_if
`default_nettype wire

// ==== core/asc_sync.sv ====
`default_nettype none
module asc_sync
  import asc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  asc_pin_if.syn pins
);
  logic [ASC_DATA_W-1:0] meta;
  logic [ASC_DATA_W-1:0] held;
  // two stages: the pins are asynchronous to our clock
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta <= '0;
      held <= '0;
    end
    else
    begin
      meta <= pins.dq_in;
      held <= meta;
    end
  end
  assign pins.dq_sync = held;
endmodule : asc_sync
`default_nettype wire

// ==== verification/asc_ctrl_properties.sv ====
`default_nettype none
module asc_ctrl_properties (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic select_low_n_o,
  input wire logic select_high_o,
  input wire logic write_n_o,
  input wire logic gate_n_o,
  input wire logic dq_oe_n_o,
  input wire logic rvalid_o,
  input wire logic [asc_pkg::ASC_ADDR_W-1:0] mem_addr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  AST_WR_SEL: assert property (!write_n_o |-> !select_low_n_o && select_high_o) else $error("no sel");
  AST_RD_WE: assert property (!gate_n_o |-> write_n_o) else $error("strobe in read");
  // memory may still drive for a cycle after the gate rises
  AST_NO_CLASH: assert property (!dq_oe_n_o |-> gate_n_o && $past(gate_n_o)) else $error("clash");
  AST_GATE_HI: assert property (!write_n_o |-> gate_n_o) else $error("gate in write");
  AST_ADDR: assert property (!select_low_n_o && $past(!select_low_n_o) |-> $stable(mem_addr_o)) else $error("addr");
  AST_DATA: assert property (!write_n_o |-> !dq_oe_n_o) else $error("no data");
  AST_DATA_HOLD: assert property ($rose(write_n_o) |-> !dq_oe_n_o) else $error("data hold");
  AST_WR_END: assert property ($fell(write_n_o) |=> write_n_o && select_low_n_o && !select_high_o) else $error("wr");
  AST_RD_LAT: assert property ($fell(gate_n_o) |=> !gate_n_o ##1 gate_n_o ##1 rvalid_o) else $error("rd");
endmodule // asc_ctrl_properties
`default_nettype wire

// ==== verification/asc_sram_model.sv ====
`default_nettype none
module asc_sram_model (
  input wire logic [asc_pkg::ASC_ADDR_W-1:0] addr_i,
  input wire logic sel_low_n_i,
  input wire logic sel_high_i,
  input wire logic write_n_i,
  input wire logic gate_n_i,
  input wire logic [asc_pkg::ASC_DATA_W-1:0] din_i,
  output logic [asc_pkg::ASC_DATA_W-1:0] dout_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:131071];
  logic [7:0] rd;
  logic sel, drv, wr_on;
  assign sel = !sel_low_n_i && sel_high_i;
  // byte lands as the overlap closes; address and data are settled then
  assign wr_on = sel && !write_n_i;
  always @(negedge wr_on)
    mem[addr_i] = din_i;
  assign #8 drv = sel && write_n_i && !gate_n_i;
  assign #20 rd = mem[addr_i];
  // floating bus shows the inverted byte
  assign dout_o = drv ? rd : ~rd;
endmodule // asc_sram_model
`default_nettype wire

// ==== verification/asc_ctrl_bench.sv ====
`default_nettype none
module asc_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import asc_pkg::*;
  logic clk_sys_i = 1'h0, rstn_i = 1'h0, req = 1'h0, req_write = 1'h0;
  logic [16:0] req_addr = 17'h0, mem_addr;
  logic [7:0] req_wdata = 8'h0, rdata, dq_o, dq_i, bus;
  logic ready, rvalid, sl_n, sh, we_n, g_n, oe_n;
  int err_count = 0, checked = 0, cycles = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  assign bus = !oe_n ? dq_o : ~dq_o;
  asc_ctrl DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .ready_o(ready), .rvalid_o(rvalid),
    .rdata_o(rdata), .mem_addr_o(mem_addr), .select_low_n_o(sl_n), .select_high_o(sh),
    .write_n_o(we_n), .gate_n_o(g_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(oe_n));
  asc_sram_model u_mem (.addr_i(mem_addr), .sel_low_n_i(sl_n), .sel_high_i(sh),
    .write_n_i(we_n), .gate_n_i(g_n), .din_i(bus), .dout_o(dq_i));
  task chk(input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) err_count++;
    if (seen !== exp) $display("Error at %0t: seen %h expected %h", $time, seen, exp);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cycles++;
    err_count += (cycles == 2000);
    if (cycles == 2000) stop_test();
  end
  // held request, dropped only once the pins show it was taken
  task automatic xf(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    req <= 1'h1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge clk_sys_i); while (we_n && g_n && ++n < 20);
    chk(mem_addr, a);
    chk(17'(ready), 17'h0);
    if (w) chk(17'({oe_n, dq_o}), 17'(d));
    else chk(17'({oe_n, we_n}), 17'h3);
    @(posedge clk_sys_i);
    req <= 1'h0;
    if (w) return;
    do @(negedge clk_sys_i); while (!rvalid && ++n < 40);
    chk(17'(rvalid), 17'h1);
    chk(17'(rdata), 17'(d));
  endtask
  task t_idle;
    @(negedge clk_sys_i);
    chk(17'({sl_n, sh, we_n, g_n, oe_n}), 17'h17);
    @(negedge clk_sys_i);
    chk(17'(ready), 17'h1);
  endtask
  // reset cuts a read short; pins fall back to idle, contents survive
  task t_reset;
    @(posedge clk_sys_i);
    req <= 1'h1;
    req_write <= 1'h0;
    req_addr <= 17'h00002;
    repeat (2) @(posedge clk_sys_i);
    req <= 1'h0;
    rstn_i <= 1'h0;
    @(negedge clk_sys_i);
    chk(17'({sl_n, sh, we_n, g_n, oe_n}), 17'h17);
    chk(17'({rvalid, ready}), 17'h0);
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    xf(1'h0, 17'h00002, 8'h81);
  endtask
  // writes then reads at the lowest, highest and top-half-start addresses
  task t_edges;
    xf(1'h1, 17'h00000, 8'hA5);
    xf(1'h1, 17'h1FFFF, 8'h5A);
    xf(1'h1, 17'h10000, 8'h3C);
    xf(1'h0, 17'h00000, 8'hA5);
    xf(1'h0, 17'h1FFFF, 8'h5A);
    xf(1'h0, 17'h10000, 8'h3C);
  endtask
  task t_over;
    xf(1'h1, 17'h00001, 8'hFF);
    xf(1'h1, 17'h00001, 8'h00);
    xf(1'h1, 17'h00002, 8'h81);
    xf(1'h0, 17'h00001, 8'h00);
    xf(1'h0, 17'h00002, 8'h81);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    t_idle();
    t_edges();
    t_over();
    t_reset();
    repeat (5) @(posedge clk_sys_i);
    stop_test();
  end
endmodule // asc_ctrl_bench
bind asc_ctrl asc_ctrl_properties u_props (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
  .select_low_n_o(select_low_n_o), .select_high_o(select_high_o), .write_n_o(write_n_o),
  .gate_n_o(gate_n_o), .dq_oe_n_o(dq_oe_n_o), .rvalid_o(rvalid_o), .mem_addr_o(mem_addr_o));
`default_nettype wire
